// [design/pstu_defines.vh]
// Command codes, status bit positions and timing constants for the status and telemetry unit
// Overview of operation
// - Fault and warning flags latch until host clears them or supplies vanish.
// - Host clears status bits with write-one-to-clear, except status byte and word.
// - Power-not-good stays set whenever the converter is not active.
// - Power-not-good clears 5 ms after the powertrain becomes active.
// - Host cannot clear power-not-good or unit-off; they mirror live state.
// - Busy clears on clear-faults, or status byte write 40h/80h on page 00h.
// - No alert output and no bus mastering; host must poll.
// - Aux-only power keeps telemetry and status; lost input adds undervoltage fault.
// - Other-fault summary set if vendor status or word high byte nonzero.
// - Communication bits set on unsupported command, data or other comm fault.
// - Reverse current sets reverse-operation bit; no reverse current value reported.
// - Protection shutdown bit on powertrain protection fault or disabled-fault event.
// - Internal link fault when converter stops responding, after first contact.
// - Page 00h vendor status read returns active converter bits.
// - Page 01h voltage reads return 0.1 V units.
// - Current reads return 0.01 A units on both pages.
// - Temperature signed degrees, power whole watts, on both pages.
// - Page 01h returns ratio scaled 2^-16 and resistance in 10^-5 ohm.
// - Rating reads A0h, A1h and A4h to A7h return factory values on either page.
// - Threshold block accepted only while disabled; bytes above 64h leave limit.
// - Limits are percent 0 to 100, default 100, never raised.
// - Fault-disable bits suppress supervisory faults; writes only while disabled.
// - Page 00h targets controller, page 01h targets powertrain.
// - Clear-faults clears all status, except link fault on page 01h, then re-asserts still-active faults.
`ifndef PSTU_DEFINES_VH
`define PSTU_DEFINES_VH
`define PSTU_CMD_PAGE        8'h00
`define PSTU_CMD_CLEAR       8'h03
`define PSTU_CMD_SBYTE       8'h78
`define PSTU_CMD_SWORD       8'h79
`define PSTU_CMD_SIOUT       8'h7B
`define PSTU_CMD_SINPUT      8'h7C
`define PSTU_CMD_STEMP       8'h7D
`define PSTU_CMD_SCML        8'h7E
`define PSTU_CMD_SMFR        8'h80
`define PSTU_CMD_VIN         8'h88
`define PSTU_CMD_IIN         8'h89
`define PSTU_CMD_VOUT        8'h8B
`define PSTU_CMD_IOUT        8'h8C
`define PSTU_CMD_TEMP        8'h8D
`define PSTU_CMD_POUT        8'h96
`define PSTU_CMD_VINMIN      8'hA0
`define PSTU_CMD_VINMAX      8'hA1
`define PSTU_CMD_VOUTMIN     8'hA4
`define PSTU_CMD_VOUTMAX     8'hA5
`define PSTU_CMD_IOUTMAX     8'hA6
`define PSTU_CMD_POUTMAX     8'hA7
`define PSTU_CMD_KFACT       8'hD1
`define PSTU_CMD_ROUT        8'hD4
`define PSTU_CMD_THRESH      8'hD5
`define PSTU_CMD_DISABLE     8'hD7
`define PSTU_PAGE_CTRL       8'h00
`define PSTU_PAGE_PT         8'h01
`define PSTU_BUSY_CLR_A      8'h40
`define PSTU_BUSY_CLR_B      8'h80
`define PSTU_PCT_MAX         8'h64
`define PSTU_PCT_DEFAULT     8'h64
// Status byte bits
`define PSTU_SB_OTHER        0
`define PSTU_SB_CML          1
`define PSTU_SB_TEMP         2
`define PSTU_SB_VINUV        3
`define PSTU_SB_IOUTOC       4
`define PSTU_SB_VOUTOV       5
`define PSTU_SB_OFF          6
`define PSTU_SB_BUSY         7
// Status word high byte bits
`define PSTU_SW_PGN          3
`define PSTU_SW_MFR          4
`define PSTU_SW_INPUT        5
`define PSTU_SW_IOUT         6
// Input, current, temperature, comm bits
`define PSTU_IN_OVF          7
`define PSTU_IN_OVW          6
`define PSTU_IN_UVF          4
`define PSTU_IO_OCF          7
`define PSTU_IO_OCW          5
`define PSTU_TP_OTF          7
`define PSTU_TP_OTW          6
`define PSTU_TP_UTF          4
`define PSTU_CML_CMD         7
`define PSTU_CML_DATA        6
`define PSTU_CML_OTHER       1
// Vendor status bits
`define PSTU_MF_REV          0
`define PSTU_MF_HWP          1
`define PSTU_MF_LINK         2
// Timing
`define PSTU_CLK_MHZ         200
`define PSTU_PGOOD_MS        5
`define PSTU_PGOOD_CYC       (`PSTU_PGOOD_MS * `PSTU_CLK_MHZ * 1000)
`define PSTU_LINK_TMO        16'h0400
`endif

// [design/pstu_status_unit.v]
// Status, telemetry and threshold command decoder behind the management bus
`include "pstu_defines.vh"
`timescale 1ns/100ps
module pstu_status_unit #(
   parameter PGOOD_CYC = `PSTU_PGOOD_CYC
) (
   input  wire        clk_i,
   input  wire        rstn_i,
   // Command port from the bus transport
   input  wire        cmd_wr_i,
   input  wire        cmd_rd_i,
   input  wire [7:0]  cmd_code_i,
   input  wire [1:0]  cmd_nbytes_i,
   input  wire [47:0] cmd_wdata_i,
   output reg  [15:0] rd_data_o,
   output reg         rd_valid_o,
   input  wire        bus_fault_i,
   // Converter state
   input  wire        pt_active_i,
   input  wire        pt_enabled_i,
   input  wire        high_side_input_i,
   input  wire        aux_controller_supply_i,
   input  wire        link_clk_i,
   input  wire        link_seen_i,
   input  wire        reverse_i,
   input  wire        hw_prot_i,
   input  wire [7:0]  sv_event_i,
   input  wire [7:0]  warn_event_i,
   input  wire [15:0] vin_i,
   input  wire [15:0] iin_i,
   input  wire [15:0] vout_i,
   input  wire [15:0] iout_i,
   input  wire [15:0] temp_i,
   input  wire [15:0] pout_i,
   input  wire [15:0] kfact_i,
   input  wire [15:0] rout_i,
   input  wire [95:0] rating_i,
   output wire [47:0] thresh_o,
   output wire [7:0]  fault_disable_o,
   output wire        alert_o
);
   // sv_event_i: 0 ov-fault, 1 oc-fault, 2 ot-fault, 3 ut-fault, 4 uv-fault
   // warn_event_i: 0 ov-warn, 1 oc-warn, 2 ot-warn

   //-------------------------------------------------------------
   // Pin synchronisers
   //-------------------------------------------------------------
   reg [2:0] act_sync_reg;
   reg [2:0] hsi_sync_reg;
   reg [2:0] lck_sync_reg;
   reg       act_reg;
   reg       hsi_reg;
   reg       lck_reg;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         act_sync_reg <= 3'h0;
         hsi_sync_reg <= 3'h0;
         lck_sync_reg <= 3'h0;
         act_reg      <= 1'b0;
         hsi_reg      <= 1'b0;
         lck_reg      <= 1'b0;
      end else begin
         act_sync_reg <= {act_sync_reg[1:0], pt_active_i};
         hsi_sync_reg <= {hsi_sync_reg[1:0], high_side_input_i};
         lck_sync_reg <= {lck_sync_reg[1:0], link_clk_i};
         if (act_sync_reg[1] == act_sync_reg[2]) act_reg <= act_sync_reg[2];
         if (hsi_sync_reg[1] == hsi_sync_reg[2]) hsi_reg <= hsi_sync_reg[2];
         if (lck_sync_reg[1] == lck_sync_reg[2]) lck_reg <= lck_sync_reg[2];
      end
   end

   //-------------------------------------------------------------
   // Link watchdog and power-good delay
   //-------------------------------------------------------------
   localparam [15:0] LINK_TMO = `PSTU_LINK_TMO;
   reg        lck_d_reg;
   reg [15:0] link_cnt_reg;
   reg        link_ever_reg;
   reg [23:0] pg_cnt_reg;
   reg        pgood_reg;
   wire       link_edge = lck_reg & ~lck_d_reg;
   wire       link_lost = link_ever_reg & act_reg & (link_cnt_reg == LINK_TMO);
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lck_d_reg     <= 1'b0;
         link_cnt_reg  <= 16'h0000;
         link_ever_reg <= 1'b0;
         pg_cnt_reg    <= 24'h000000;
         pgood_reg     <= 1'b0;
      end else begin
         lck_d_reg <= lck_reg;
         if (link_edge | ~act_reg)
            link_cnt_reg <= 16'h0000;
         else if (link_cnt_reg != LINK_TMO)
            link_cnt_reg <= link_cnt_reg + 16'h0001;
         if (link_edge & link_seen_i)
            link_ever_reg <= 1'b1;
         if (!act_reg) begin
            pg_cnt_reg <= 24'h000000;
            pgood_reg  <= 1'b0;
         end else if (pg_cnt_reg >= PGOOD_CYC[23:0] - 24'h000001) begin
            pgood_reg  <= 1'b1;
         end else begin
            pg_cnt_reg <= pg_cnt_reg + 24'h000001;
         end
      end
   end

   //-------------------------------------------------------------
   // Write decoding
   //-------------------------------------------------------------
   reg [7:0] page_reg;
   wire pg0       = (page_reg == `PSTU_PAGE_CTRL);
   wire pg1       = (page_reg == `PSTU_PAGE_PT);
   wire clr_all   = cmd_wr_i & (cmd_code_i == `PSTU_CMD_CLEAR);
   wire w1c_pt    = cmd_wr_i & pg1;
   wire [7:0] wb  = cmd_wdata_i[7:0];
   wire clr_iout  = w1c_pt & (cmd_code_i == `PSTU_CMD_SIOUT);
   wire clr_in    = w1c_pt & (cmd_code_i == `PSTU_CMD_SINPUT);
   wire clr_tmp   = w1c_pt & (cmd_code_i == `PSTU_CMD_STEMP);
   wire clr_mfr   = w1c_pt & (cmd_code_i == `PSTU_CMD_SMFR);
   wire clr_cml   = cmd_wr_i & pg0 & (cmd_code_i == `PSTU_CMD_SCML);
   wire sb_wr     = cmd_wr_i & pg0 & (cmd_code_i == `PSTU_CMD_SBYTE);
   wire busy_clr  = clr_all | (sb_wr & ((wb == `PSTU_BUSY_CLR_A) |
                    (wb == `PSTU_BUSY_CLR_B)));
   wire thr_wr    = cmd_wr_i & pg1 & (cmd_code_i == `PSTU_CMD_THRESH);
   wire dis_wr    = cmd_wr_i & pg1 & (cmd_code_i == `PSTU_CMD_DISABLE);
   wire cfg_ok    = ~pt_enabled_i;

   reg cmd_ok;
   always @* begin
      case (cmd_code_i)
         `PSTU_CMD_PAGE:   cmd_ok = 1'b1;
         `PSTU_CMD_CLEAR:  cmd_ok = 1'b1;
         `PSTU_CMD_SBYTE:  cmd_ok = cmd_rd_i | pg0;
         `PSTU_CMD_SWORD:  cmd_ok = cmd_rd_i;
         `PSTU_CMD_SIOUT, `PSTU_CMD_SINPUT, `PSTU_CMD_STEMP, `PSTU_CMD_SMFR:
            cmd_ok = cmd_rd_i | pg1;
         `PSTU_CMD_SCML:   cmd_ok = pg0;
         `PSTU_CMD_VIN, `PSTU_CMD_VOUT, `PSTU_CMD_KFACT, `PSTU_CMD_ROUT:
            cmd_ok = cmd_rd_i & pg1;
         `PSTU_CMD_IIN, `PSTU_CMD_IOUT, `PSTU_CMD_TEMP, `PSTU_CMD_POUT,
         `PSTU_CMD_VINMIN, `PSTU_CMD_VINMAX, `PSTU_CMD_VOUTMIN, `PSTU_CMD_VOUTMAX,
         `PSTU_CMD_IOUTMAX, `PSTU_CMD_POUTMAX:
            cmd_ok = cmd_rd_i;
         `PSTU_CMD_THRESH, `PSTU_CMD_DISABLE: cmd_ok = pg1;
         default:          cmd_ok = 1'b0;
      endcase
   end
   wire any_cmd  = cmd_wr_i | cmd_rd_i;
   wire bad_cmd  = any_cmd & ~cmd_ok;
   wire bad_data = (cmd_wr_i & cmd_ok & (cmd_code_i == `PSTU_CMD_PAGE) &
                    (wb > `PSTU_PAGE_PT)) |
                   ((thr_wr | dis_wr) & ~cfg_ok);

   //-------------------------------------------------------------
   // Thresholds and fault disables
   //-------------------------------------------------------------
   reg [7:0] thr_reg [0:5];
   reg [7:0] dis_reg;
   integer   i;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (i = 0; i < 6; i = i + 1)
            thr_reg[i] <= `PSTU_PCT_DEFAULT;
         dis_reg  <= 8'h00;
         page_reg <= `PSTU_PAGE_CTRL;
      end else begin
         if (thr_wr & cfg_ok) begin
            for (i = 0; i < 6; i = i + 1)
               if (cmd_wdata_i[i*8 +: 8] <= `PSTU_PCT_MAX)
                  thr_reg[i] <= cmd_wdata_i[i*8 +: 8];
         end
         if (dis_wr & cfg_ok)
            dis_reg <= wb;
         if (cmd_wr_i & (cmd_code_i == `PSTU_CMD_PAGE) & (wb <= `PSTU_PAGE_PT))
            page_reg <= wb;
      end
   end
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_thr
         assign thresh_o[g*8 +: 8] = thr_reg[g];
      end
   endgenerate
   assign fault_disable_o = dis_reg;
   assign alert_o         = 1'b0;

   //-------------------------------------------------------------
   // Latched status flags
   //-------------------------------------------------------------
   wire [7:0] sv_live  = sv_event_i & ~dis_reg;
   wire       dis_hit  = |(sv_event_i & dis_reg);
   wire       uv_live  = sv_live[4] | ~hsi_reg;
   // Clear-faults on the powertrain page spares the link fault bit
   wire [7:0] mf_clr   = clr_all ? (pg0 ? 8'hFF : ~(8'h01 << `PSTU_MF_LINK)) :
                         (clr_mfr ? wb : 8'h00);
   reg  [7:0] st_in_reg, st_io_reg, st_tp_reg, st_cml_reg, st_mf_reg;
   reg        busy_reg;
   reg  [7:0] in_set, io_set, tp_set, cml_set, mf_set;
   always @* begin
      in_set = 8'h00;
      io_set = 8'h00;
      tp_set = 8'h00;
      cml_set = 8'h00;
      mf_set = 8'h00;
      in_set[`PSTU_IN_OVF]   = sv_live[0];
      in_set[`PSTU_IN_OVW]   = warn_event_i[0];
      in_set[`PSTU_IN_UVF]   = uv_live;
      io_set[`PSTU_IO_OCF]   = sv_live[1];
      io_set[`PSTU_IO_OCW]   = warn_event_i[1];
      tp_set[`PSTU_TP_OTF]   = sv_live[2];
      tp_set[`PSTU_TP_OTW]   = warn_event_i[2];
      tp_set[`PSTU_TP_UTF]   = sv_live[3];
      cml_set[`PSTU_CML_CMD]   = bad_cmd;
      cml_set[`PSTU_CML_DATA]  = bad_data;
      cml_set[`PSTU_CML_OTHER] = bus_fault_i;
      mf_set[`PSTU_MF_REV]   = reverse_i;
      mf_set[`PSTU_MF_HWP]   = hw_prot_i | dis_hit;
      mf_set[`PSTU_MF_LINK]  = link_lost;
   end
   // Set wins over clear; clear-faults wipes then re-asserts active ones
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_in_reg  <= 8'h00;
         st_io_reg  <= 8'h00;
         st_tp_reg  <= 8'h00;
         st_cml_reg <= 8'h00;
         st_mf_reg  <= 8'h00;
         busy_reg   <= 1'b0;
      end else begin
         st_in_reg  <= (clr_all ? 8'h00 : st_in_reg & ~(clr_in ? wb : 8'h00)) | in_set;
         st_io_reg  <= (clr_all ? 8'h00 : st_io_reg & ~(clr_iout ? wb : 8'h00)) | io_set;
         st_tp_reg  <= (clr_all ? 8'h00 : st_tp_reg & ~(clr_tmp ? wb : 8'h00)) | tp_set;
         st_cml_reg <= (clr_all ? 8'h00 : st_cml_reg & ~(clr_cml ? wb : 8'h00)) | cml_set;
         st_mf_reg  <= (st_mf_reg & ~mf_clr) | mf_set;
         if (busy_clr)
            busy_reg <= 1'b0;
      end
   end

   //-------------------------------------------------------------
   // Summary byte and word
   //-------------------------------------------------------------
   reg [7:0] sw_hi;
   reg [7:0] sb;
   always @* begin
      sw_hi = 8'h00;
      sw_hi[`PSTU_SW_PGN]   = ~pgood_reg;
      sw_hi[`PSTU_SW_MFR]   = |st_mf_reg;
      sw_hi[`PSTU_SW_INPUT] = |st_in_reg;
      sw_hi[`PSTU_SW_IOUT]  = |st_io_reg;
      sb = 8'h00;
      sb[`PSTU_SB_BUSY]   = busy_reg;
      sb[`PSTU_SB_OFF]    = ~act_reg;
      sb[`PSTU_SB_IOUTOC] = st_io_reg[`PSTU_IO_OCF];
      sb[`PSTU_SB_VINUV]  = st_in_reg[`PSTU_IN_UVF];
      sb[`PSTU_SB_TEMP]   = |st_tp_reg;
      sb[`PSTU_SB_CML]    = |st_cml_reg;
      sb[`PSTU_SB_OTHER]  = (|st_mf_reg) | (|sw_hi);
   end

   //-------------------------------------------------------------
   // Read mux
   //-------------------------------------------------------------
   reg [15:0] rd_next;
   always @* begin
      case (cmd_code_i)
         `PSTU_CMD_SBYTE:   rd_next = {8'h00, sb};
         `PSTU_CMD_SWORD:   rd_next = {sw_hi, sb};
         `PSTU_CMD_SIOUT:   rd_next = {8'h00, st_io_reg};
         `PSTU_CMD_SINPUT:  rd_next = {8'h00, st_in_reg};
         `PSTU_CMD_STEMP:   rd_next = {8'h00, st_tp_reg};
         `PSTU_CMD_SCML:    rd_next = {8'h00, st_cml_reg};
         `PSTU_CMD_SMFR:    rd_next = {8'h00, st_mf_reg};
         `PSTU_CMD_VIN:     rd_next = vin_i;
         `PSTU_CMD_VOUT:    rd_next = vout_i;
         `PSTU_CMD_IIN:     rd_next = iin_i;
         `PSTU_CMD_IOUT:    rd_next = iout_i;
         `PSTU_CMD_TEMP:    rd_next = temp_i;
         `PSTU_CMD_POUT:    rd_next = pout_i;
         `PSTU_CMD_KFACT:   rd_next = kfact_i;
         `PSTU_CMD_ROUT:    rd_next = rout_i;
         `PSTU_CMD_VINMIN:  rd_next = rating_i[15:0];
         `PSTU_CMD_VINMAX:  rd_next = rating_i[31:16];
         `PSTU_CMD_VOUTMIN: rd_next = rating_i[47:32];
         `PSTU_CMD_VOUTMAX: rd_next = rating_i[63:48];
         `PSTU_CMD_IOUTMAX: rd_next = rating_i[79:64];
         `PSTU_CMD_POUTMAX: rd_next = rating_i[95:80];
         `PSTU_CMD_PAGE:    rd_next = {8'h00, page_reg};
         `PSTU_CMD_THRESH:  rd_next = {thr_reg[1], thr_reg[0]};
         `PSTU_CMD_DISABLE: rd_next = {8'h00, dis_reg};
         default:           rd_next = 16'hFFFF;
      endcase
   end
   // Telemetry comes straight from held inputs so aux-only power keeps it readable
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_o  <= 16'h0000;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= cmd_rd_i & cmd_ok & aux_controller_supply_i;
         if (cmd_rd_i)
            rd_data_o <= cmd_ok ? rd_next : 16'hFFFF;
      end
   end
endmodule // pstu_status_unit

// [tb/pstu_status_checker_assertions.sv]
// Port-level checks on the status and telemetry unit
`timescale 1ns/100ps
module pstu_status_checker (
   input wire        clk_i,
   input wire        rstn_i,
   input wire        cmd_wr_i,
   input wire        cmd_rd_i,
   input wire [7:0]  cmd_code_i,
   input wire [47:0] cmd_wdata_i,
   input wire        rd_valid_o,
   input wire        pt_enabled_i,
   input wire        aux_controller_supply_i,
   input wire [47:0] thresh_o,
   input wire [7:0]  fault_disable_o,
   input wire        alert_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   a_no_alert: assert property (alert_o == 1'b0)
      else $error("alert output driven");
   a_valid_has_read: assert property (rd_valid_o |-> $past(cmd_rd_i))
      else $error("read valid without a read");
   a_aux_read: assert property (cmd_rd_i && !aux_controller_supply_i |=> !rd_valid_o)
      else $error("read answered without aux supply");
   a_pct_range: assert property (thresh_o[7:0] <= 8'h64 && thresh_o[15:8] <= 8'h64 &&
      thresh_o[23:16] <= 8'h64 && thresh_o[31:24] <= 8'h64 && thresh_o[39:32] <= 8'h64 &&
      thresh_o[47:40] <= 8'h64)
      else $error("threshold above full scale");
   a_thr_quiet: assert property (!cmd_wr_i |=> $stable(thresh_o))
      else $error("thresholds moved without a write");
   a_dis_quiet: assert property (!cmd_wr_i |=> $stable(fault_disable_o))
      else $error("fault disable moved without a write");
   a_enabled_lock: assert property (cmd_wr_i && pt_enabled_i |=>
      $stable(thresh_o) && $stable(fault_disable_o))
      else $error("config changed while converter enabled");
   a_keep_byte: assert property (cmd_wr_i && cmd_code_i == 8'hD5 &&
      cmd_wdata_i[39:32] > 8'h64 |=> $stable(thresh_o[39:32]))
      else $error("oversized threshold byte was stored");
endmodule // pstu_status_checker

bind pstu_status_unit pstu_status_checker pstu_status_checker_i (
   .clk_i(clk_i), .rstn_i(rstn_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
   .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .rd_valid_o(rd_valid_o),
   .pt_enabled_i(pt_enabled_i), .aux_controller_supply_i(aux_controller_supply_i),
   .thresh_o(thresh_o), .fault_disable_o(fault_disable_o), .alert_o(alert_o));

// [tb/pstu_host_model.sv]
// Host model that issues one management command at a time
`timescale 1ns/100ps
module pstu_host_model (
   input  wire        clk_i,
   output reg         cmd_wr_o,
   output reg         cmd_rd_o,
   output reg  [7:0]  cmd_code_o,
   output reg  [47:0] cmd_wdata_o,
   input  wire [15:0] rd_data_i,
   input  wire        rd_valid_i
);
   initial begin
      {cmd_wr_o, cmd_rd_o} = 2'h0;
      cmd_code_o = 8'hFF;
      cmd_wdata_o = 48'h0;
   end
   // Ones in the data clear flags; page writes steer what follows
   task wr(input [7:0] code, input [47:0] data);
      begin
         @(posedge clk_i) #1;
         cmd_code_o = code;
         cmd_wdata_o = data;
         cmd_wr_o = 1'b1;
         @(posedge clk_i) #1;
         cmd_wr_o = 1'b0;
         cmd_code_o = ~code;
         cmd_wdata_o = ~data;
      end
   endtask
   // Faults are only learned by polling
   task rd(input [7:0] code, output [15:0] data, output ok);
      begin
         @(posedge clk_i) #1;
         cmd_code_o = code;
         cmd_rd_o = 1'b1;
         @(posedge clk_i) #1;
         data = rd_data_i;
         ok = rd_valid_i;
         cmd_rd_o = 1'b0;
         cmd_code_o = ~code;
      end
   endtask
endmodule // pstu_host_model

// [tb/pstu_status_unit_bench.sv]
// Self-checking bench for the status and telemetry unit
`timescale 1ns/100ps
module pstu_status_unit_bench;
   // ---------------------------------------------------------------
   // Telemetry values and read table {page, code, slot}
   // ---------------------------------------------------------------
   localparam [223:0] TEL = {112'h0546_0096_0064_003C_0258_0168_0032,
                             112'h2AAB_0546_FFE7_2EE0_005A_0190_021C};
   localparam [19:0] ROWS [0:19] = '{20'h01880, 20'h01891, 20'h018B2, 20'h018C3,
      20'h018D4, 20'h01965, 20'h01D16, 20'h01D47, 20'h01A08, 20'h01A19, 20'h01A4A,
      20'h01A5B, 20'h01A6C, 20'h01A7D, 20'h00891, 20'h008C3, 20'h008D4, 20'h00965,
      20'h00A08, 20'h00A7D};
   reg         clk_i, rstn_i, pt_active_i, pt_enabled_i, hsi_i, aux_i, link_clk_i;
   reg         link_seen_i, reverse_i, hw_prot_i, bus_fault_i, rval;
   reg  [7:0]  sv_event_i;
   reg  [15:0] rdat;
   integer     fail_count, samples_checked, n;
   wire        cmd_wr, cmd_rd, rd_valid;
   wire [7:0]  cmd_code, fault_dis;
   wire [47:0] cmd_wdata, thresh;
   wire [15:0] rd_data;

   pstu_status_unit #(.PGOOD_CYC(50)) pstu_status_unit_i (
      .clk_i(clk_i), .rstn_i(rstn_i), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd),
      .cmd_code_i(cmd_code), .cmd_nbytes_i(2'h2), .cmd_wdata_i(cmd_wdata),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .bus_fault_i(bus_fault_i),
      .pt_active_i(pt_active_i), .pt_enabled_i(pt_enabled_i),
      .high_side_input_i(hsi_i), .aux_controller_supply_i(aux_i),
      .link_clk_i(link_clk_i), .link_seen_i(link_seen_i), .reverse_i(reverse_i),
      .hw_prot_i(hw_prot_i), .sv_event_i(sv_event_i), .warn_event_i(8'h00),
      .vin_i(TEL[15:0]), .iin_i(TEL[31:16]), .vout_i(TEL[47:32]), .iout_i(TEL[63:48]),
      .temp_i(TEL[79:64]), .pout_i(TEL[95:80]), .kfact_i(TEL[111:96]),
      .rout_i(TEL[127:112]), .rating_i(TEL[223:128]), .thresh_o(thresh),
      .fault_disable_o(fault_dis), .alert_o());
   pstu_host_model pstu_host_model_i (.clk_i(clk_i), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
      .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata), .rd_data_i(rd_data),
      .rd_valid_i(rd_valid));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task tick(input integer c);
      begin
         repeat (c) @(posedge clk_i);
         #1;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd(input [7:0] code);
      pstu_host_model_i.rd(code, rdat, rval);
   endtask
   task wr(input [7:0] code, input [47:0] d);
      pstu_host_model_i.wr(code, d);
   endtask
   task pg(input [7:0] p);
      wr(8'h00, {40'h0, p});
   endtask
   task link_burst(input integer c);
      repeat (c) begin
         #40 link_clk_i = 1'b1;
         #40 link_clk_i = 1'b0;
      end
   endtask
   task done(input [63:0] nm);
      $display("test %0s done", nm);
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      fail_count = fail_count + 1;
      results;
   end
   initial begin
      {rstn_i, pt_active_i, pt_enabled_i, link_clk_i, link_seen_i} = 5'h00;
      {reverse_i, hw_prot_i, bus_fault_i, hsi_i, aux_i} = 5'h03;
      sv_event_i = 8'h00;
      fail_count = 0;
      samples_checked = 0;
      tick(20);
      rstn_i = 1'b1;
      tick(6);
      chk(thresh[47:32], 16'h6464);
      chk({8'h00, fault_dis}, 16'h0000);
      done("reset");
      for (n = 0; n < 20; n = n + 1) begin
         pg(ROWS[n][19:12]);
         rd(ROWS[n][11:4]);
         chk(rdat, TEL[ROWS[n][3:0]*16 +: 16]);
      end
      done("telem");
      pg(8'h00);
      rd(8'h79);
      chk(rdat & 16'h0800, 16'h0800);
      pt_active_i = 1'b1;
      tick(30);
      rd(8'h79);
      chk(rdat & 16'h0800, 16'h0800);
      tick(40);
      rd(8'h79);
      chk(rdat & 16'h0800, 16'h0000);
      pt_active_i = 1'b0;
      tick(8);
      wr(8'h78, 48'h40);
      rd(8'h79);
      chk(rdat & 16'h0880, 16'h0800);
      done("pgood");
      pt_active_i = 1'b1;
      link_seen_i = 1'b1;
      link_burst(8);
      tick(1100);
      rd(8'h80);
      chk(rdat & 16'h0004, 16'h0004);
      pg(8'h01);
      wr(8'h03, 48'h0);
      rd(8'h80);
      chk(rdat & 16'h0004, 16'h0004);
      rd(8'h78);
      chk(rdat & 16'h0001, 16'h0001);
      link_burst(2);
      pg(8'h00);
      wr(8'h03, 48'h0);
      rd(8'h80);
      chk(rdat & 16'h0004, 16'h0000);
      done("link");
      pg(8'h01);
      {reverse_i, hw_prot_i} = 2'h3;
      tick(10);
      {reverse_i, hw_prot_i} = 2'h0;
      tick(10);
      rd(8'h80);
      chk(rdat & 16'h0003, 16'h0003);
      wr(8'h80, 48'h01);
      rd(8'h80);
      chk(rdat & 16'h0003, 16'h0002);
      wr(8'h80, 48'h02);
      wr(8'hD7, 48'h01);
      chk({8'h00, fault_dis}, 16'h0001);
      sv_event_i = 8'h01;
      tick(4);
      sv_event_i = 8'h00;
      tick(4);
      rd(8'h80);
      chk(rdat & 16'h0002, 16'h0002);
      rd(8'h7C);
      chk(rdat & 16'h0080, 16'h0000);
      done("vendor");
      pt_enabled_i = 1'b1;
      wr(8'hD7, 48'h00);
      wr(8'hD5, 48'h00);
      chk({8'h00, fault_dis}, 16'h0001);
      chk(thresh[15:0], 16'h6464);
      pg(8'h00);
      rd(8'h7E);
      chk(rdat & 16'h0040, 16'h0040);
      wr(8'h7E, 48'hFF);
      pg(8'h01);
      pt_enabled_i = 1'b0;
      wr(8'hD5, 48'h10FF00645065);
      chk(thresh[15:0], 16'h5064);
      chk(thresh[31:16], 16'h0064);
      chk(thresh[47:32], 16'h1064);
      done("thresh");
      pg(8'h00);
      rd(8'h88);
      chk({rval, rdat[14:0]}, 16'h7FFF);
      rd(8'h7E);
      chk(rdat & 16'h0080, 16'h0080);
      bus_fault_i = 1'b1;
      tick(1);
      bus_fault_i = 1'b0;
      wr(8'h7E, 48'h80);
      rd(8'h7E);
      chk(rdat & 16'h0082, 16'h0002);
      done("comm");
      pg(8'h01);
      aux_i = 1'b0;
      rd(8'h88);
      chk({15'h0, rval}, 16'h0000);
      aux_i = 1'b1;
      hsi_i = 1'b0;
      tick(10);
      rd(8'h7C);
      chk(rdat & 16'h0010, 16'h0010);
      rd(8'h88);
      chk(rdat, TEL[15:0]);
      done("aux");
      rstn_i = 1'b0;
      tick(2);
      rstn_i = 1'b1;
      tick(6);
      chk(thresh[15:0], 16'h6464);
      rd(8'h7E);
      chk({rval, rdat[14:0]}, 16'h8000);
      done("reset2");
      results;
   end
endmodule // pstu_status_unit_bench
